/* ehic_mem_model.sv */
module ehic_mem_model (
   input wire logic pclk,
   input wire logic [15:0] ad_out,
   input wire logic ad_oe,
   input wire logic [7:0] addr_hi,
   input wire ehic_pkg::ehic_strobes_t strobes,
   input wire logic strobe_oe,
   output logic [15:0] ad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import ehic_pkg::*;
   logic [23:0] lat_addr = 24'h000000;
   logic [15:0] last_drv = 16'h0000;
   logic [1:0] wr_lanes = 2'h0;
   logic [15:0] wr_data = 16'h0000;
   int address_latch_strobe_cnt = 0;
   logic rd_on;
   logic [1:0] wr_style0;
   logic [1:0] wr_style1;
   logic [1:0] lanes;
   function automatic logic [15:0] mem_half(input logic [23:0] a);
      return a[15:0] ^ {a[23:16], a[23:16]};
   endfunction
   // Direction counts only while the data strobe is low, so a brief high
   // level on it just before the bus is released is harmless.
   assign rd_on = strobe_oe && ((!strobes.data_strobe_n && strobes.rw) ||
                                !strobes.read_strobe_n);
   assign wr_style0 = (!strobes.data_strobe_n && !strobes.rw) ?
      ~{strobes.high_byte_enable_n, strobes.low_byte_enable_n} : 2'h0;
   assign wr_style1 = ~{strobes.write_high_strobe_n, strobes.write_low_strobe_n};
   assign lanes = strobe_oe ? (wr_style0 | wr_style1) : 2'h0;
   // The lines have no pull, so an undriven bus shows a value that changes
   // every cycle rather than the last data.
   assign ad_in = rd_on ? mem_half(lat_addr) : ~last_drv;
   always @(posedge pclk) begin
      last_drv <= ad_in;
      if (strobe_oe && ad_oe && strobes.address_latch_strobe) begin
         lat_addr <= {addr_hi, ad_out};
         address_latch_strobe_cnt <= address_latch_strobe_cnt + 1;
      end
      // Only enabled lanes are meaningful; the other lane is ignored.
      if (lanes != 2'h0) begin
         wr_lanes <= lanes;
         wr_data <= ad_out;
      end
   end
endmodule

/* ehic_pkg.sv */
package ehic_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_T1 = 3'b001,
      S_T2 = 3'b010,
      S_T3 = 3'b011,
      S_TI = 3'b100,
      S_HOLD = 3'b101
   } ehic_state_t;
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_WORD = 2'b10
   } ehic_size_t;
   typedef enum logic [1:0] {
      K_OP = 2'b00,
      K_BR = 2'b01,
      K_SEQ = 2'b10
   } ehic_kind_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic rmw;
      ehic_size_t size;
      logic [23:0] addr;
      logic [31:0] wdata;
   } ehic_op_req_t;
   typedef struct packed {
      logic valid;
      logic [23:0] addr;
   } ehic_fetch_req_t;
   typedef struct packed {
      logic address_latch_strobe;
      logic data_strobe_n;
      logic rw;
      logic low_byte_enable_n;
      logic high_byte_enable_n;
      logic read_strobe_n;
      logic write_low_strobe_n;
      logic write_high_strobe_n;
   } ehic_strobes_t;
endpackage

/* ehic_regs.svh */
`ifndef EHIC_REGS_SVH
`define EHIC_REGS_SVH
// Behaviour
// - Idle control register is 16 bits, read/write, resets to AAAAh.
// - Odd bit 2n+1 enables one idle state for block pair n.
// - Block 0 accesses never get an idle state.
// - Block 15 internal RAM and peripheral accesses never get an idle state.
// - Hold request and acknowledge work only while the hold pin enable is 1.
// - Low hold request floats address/data and strobes; high drives them again.
// - Hold acknowledge stays low for the whole hold.
// - During hold, work continues until the next external access stalls; the code accepts no request while held.
// - No hold is granted inside a read-modify-write pair.
// - Stop and idle power modes never enter hold.
// - In halt, hold is acknowledged at once and released with the request.
// - Two strobe styles, both with the address strobe, chosen by a bit.
// - Byte writes may put don't-care data on the unused lane.
// - Hold request is sampled at the end of a cycle; high means no hold.
// - Direction output may go high just before hold acknowledge falls.
// - Priority: hold, operand, branch fetch, continuous fetch.
// - A fetch may run between the read and write of a read-modify-write.
// - Word halves run back to back with no fetch or hold between.
// - Fetches in the peripheral area return the no-op code, no bus cycle.
// - Prefetch running on into the peripheral area is suppressed.
// - Halfword and word data accesses are aligned to their size.
// - An enabled idle state follows the third bus state before the next cycle.
// - The 16 MB space splits into sixteen 1 MB blocks by upper address bits.
// - Style bit 0 gives strobe, direction, byte enables; 1 gives read/write strobes; the code also drives direction and high byte enable in style 1.
`define IDLE_CTRL_IDX 32'hFFFFF062
`define MEM_MODE_IDX 32'hFFFFF070
`define SYS_CTRL_IDX 32'hFFFFF071
`define BUS_STAT_IDX 32'hFFFFF072
`define IDLE_CTRL_RST 16'hAAAA
`define MEM_MODE_RST 8'h00
`define SYS_CTRL_RST 8'h00
`define HOLD_EN_BIT 3
`define STYLE_BIT 0
`define BLK_ROM 4'h0
`define BLK_INT 4'hF
`define PERIPH_TAG 12'hFFF
`define NOP_CODE 16'h0000
`endif

/* ehic_top.sv */
`include "ehic_regs.svh"
module ehic_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ehic_pkg::ehic_op_req_t op_req,
   output logic op_accept,
   output logic op_done,
   input wire ehic_pkg::ehic_fetch_req_t br_req,
   output logic br_accept,
   output logic br_done,
   input wire ehic_pkg::ehic_fetch_req_t seq_req,
   output logic seq_accept,
   output logic seq_done,
   output logic [31:0] rd_data,
   input wire logic pwr_stop_idle,
   input wire logic hold_request_n,
   output logic hold_ack_n,
   input wire logic [15:0] ad_in,
   output logic [15:0] ad_out,
   output logic ad_oe,
   output logic [7:0] addr_hi,
   output ehic_pkg::ehic_strobes_t strobes,
   output logic strobe_oe
);
   import ehic_pkg::*;

   function automatic logic [31:0] byte_addr(input logic [31:0] idx);
      return {idx[29:0], 2'b00};
   endfunction

   function automatic logic in_periph(input logic [23:0] a);
      return a[23:12] == `PERIPH_TAG;
   endfunction

   logic [15:0] idle_ctrl_reg;
   logic [7:0] mem_mode_reg;
   logic [7:0] sys_ctrl_reg;
   logic [31:0] prdata_reg;
   ehic_state_t state_reg;
   ehic_state_t state_next;
   ehic_kind_t kind_reg;
   ehic_size_t size_reg;
   logic [23:0] addr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic write_reg;
   logic rmw_reg;
   logic half_reg;
   logic cont_reg;
   logic rmw_lock_reg;
   logic [2:0] done_reg;

   // Register slave. It always answers in one access cycle.
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic hit_ic = paddr == byte_addr(`IDLE_CTRL_IDX);
   wire logic hit_mm = paddr == byte_addr(`MEM_MODE_IDX);
   wire logic hit_sc = paddr == byte_addr(`SYS_CTRL_IDX);
   wire logic hit_st = paddr == byte_addr(`BUS_STAT_IDX);
   wire logic hit_any = hit_ic | hit_mm | hit_sc | hit_st;
   wire logic wr_en = access & pwrite;
   wire logic hold_active = state_reg == S_HOLD;
   wire logic [7:0] status = {hold_active, rmw_lock_reg, half_reg, 2'b00,
                              state_reg};
   wire logic [31:0] rd_mux = hit_ic ? {16'h0000, idle_ctrl_reg} :
                              hit_mm ? {24'h000000, mem_mode_reg} :
                              hit_sc ? {24'h000000, sys_ctrl_reg} :
                              hit_st ? {24'h000000, status} : 32'h00000000;

   assign pready = 1'b1;
   assign pslverr = access & ~hit_any;
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_ctrl_reg <= `IDLE_CTRL_RST;
         mem_mode_reg <= `MEM_MODE_RST;
         sys_ctrl_reg <= `SYS_CTRL_RST;
         prdata_reg <= 32'h00000000;
      end else begin
         if (setup) begin
            prdata_reg <= rd_mux;
         end
         if (wr_en & hit_ic) begin
            // Even bits are stored as written; software must keep them 0.
            idle_ctrl_reg <= pwdata[15:0];
         end
         if (wr_en & hit_mm) begin
            mem_mode_reg <= pwdata[7:0];
         end
         if (wr_en & hit_sc) begin
            sys_ctrl_reg <= pwdata[7:0];
         end
      end
   end

   // Idle control per block pair, blocks taken from the top address bits.
   logic [7:0] pair_on;
   genvar n;
   generate
      for (n = 0; n < 8; n++) begin : g_pair
         assign pair_on[n] = idle_ctrl_reg[2 * n + 1];
      end
   endgenerate

   wire logic [3:0] cur_blk = addr_reg[23:20];
   wire logic idle_en = pair_on[cur_blk[3:1]] & (cur_blk != `BLK_ROM) &
                        (cur_blk != `BLK_INT);

   // Arbitration. Hold is only looked at between bus cycles.
   wire logic in_idle = state_reg == S_IDLE;
   wire logic hold_pins_en = mem_mode_reg[`HOLD_EN_BIT];
   wire logic hold_req = hold_pins_en & ~hold_request_n;
   wire logic hold_grant = hold_req & ~rmw_lock_reg &
                           ~pwr_stop_idle;
   wire logic pick_ok = in_idle & ~hold_grant;

   assign op_accept = pick_ok & op_req.valid;
   assign br_accept = pick_ok & ~op_req.valid & br_req.valid;
   assign seq_accept = pick_ok & ~op_req.valid & ~br_req.valid &
                       seq_req.valid;

   wire logic br_nop = br_accept & in_periph(br_req.addr);
   wire logic seq_nop = seq_accept & in_periph(seq_req.addr);
   wire logic start_bus = op_accept | (br_accept & ~br_nop) |
                          (seq_accept & ~seq_nop);

   // Data accesses are forced onto their natural boundary.
   wire logic [23:0] op_addr_al =
      op_req.size == SZ_WORD ? {op_req.addr[23:2], 2'b00} :
      op_req.size == SZ_HALF ? {op_req.addr[23:1], 1'b0} :
      op_req.addr;

   wire logic more = (size_reg == SZ_WORD) & ~half_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (hold_grant) begin
               state_next = S_HOLD;
            end else if (start_bus) begin
               state_next = S_T1;
            end
         end
         S_T1: begin
            state_next = S_T2;
         end
         S_T2: begin
            state_next = S_T3;
         end
         S_T3: begin
            if (idle_en) begin
               state_next = S_TI;
            end else if (more) begin
               state_next = S_T1;
            end else begin
               state_next = S_IDLE;
            end
         end
         S_TI: begin
            state_next = cont_reg ? S_T1 : S_IDLE;
         end
         S_HOLD: begin
            if (!hold_req) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // Core requests simply wait unanswered while the bus is held.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   wire logic [15:0] rd_lane = addr_reg[0] ? {8'h00, ad_in[15:8]} :
                               {8'h00, ad_in[7:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kind_reg <= K_OP;
         size_reg <= SZ_HALF;
         addr_reg <= 24'h000000;
         wdata_reg <= 32'h00000000;
         rdata_reg <= 32'h00000000;
         write_reg <= 1'b0;
         rmw_reg <= 1'b0;
         half_reg <= 1'b0;
         cont_reg <= 1'b0;
         rmw_lock_reg <= 1'b0;
         done_reg <= 3'b000;
      end else begin
         done_reg <= 3'b000;
         if (op_accept) begin
            kind_reg <= K_OP;
            size_reg <= op_req.size;
            addr_reg <= op_addr_al;
            write_reg <= op_req.write;
            rmw_reg <= op_req.rmw;
            wdata_reg <= op_req.wdata;
            half_reg <= 1'b0;
         end else if (br_accept | seq_accept) begin
            kind_reg <= br_accept ? K_BR : K_SEQ;
            size_reg <= SZ_HALF;
            addr_reg <= br_accept ? br_req.addr : seq_req.addr;
            write_reg <= 1'b0;
            rmw_reg <= 1'b0;
            half_reg <= 1'b0;
            if (br_nop | seq_nop) begin
               rdata_reg <= {16'h0000, `NOP_CODE};
               done_reg <= br_nop ? 3'b010 : 3'b100;
            end
         end
         if (state_reg == S_T3) begin
            if (!write_reg) begin
               unique case (size_reg)
                  SZ_BYTE: rdata_reg <= {16'h0000, rd_lane};
                  SZ_WORD: rdata_reg <= half_reg ?
                     {ad_in, rdata_reg[15:0]} : {16'h0000, ad_in};
                  default: rdata_reg <= {16'h0000, ad_in};
               endcase
            end
            if (more) begin
               cont_reg <= idle_en;
               half_reg <= ~idle_en;
            end else begin
               done_reg[kind_reg] <= 1'b1;
               if (kind_reg == K_OP) begin
                  // The lock spans a fetch but never a hold.
                  rmw_lock_reg <= rmw_reg & ~write_reg;
               end
            end
         end
         if (state_reg == S_TI && cont_reg) begin
            half_reg <= 1'b1;
            cont_reg <= 1'b0;
         end
      end
   end

   assign op_done = done_reg[0];
   assign br_done = done_reg[1];
   assign seq_done = done_reg[2];
   assign rd_data = rdata_reg;

   // Pin drive. Strobes decode straight from flops, one level of logic.
   wire logic [23:0] eff_addr = {addr_reg[23:2], addr_reg[1] | half_reg,
                                 addr_reg[0]};
   wire logic byte_acc = size_reg == SZ_BYTE;
   wire logic lo_lane = ~byte_acc | ~eff_addr[0];
   wire logic hi_lane = ~byte_acc | eff_addr[0];
   wire logic in_t1 = state_reg == S_T1;
   wire logic active = (state_reg == S_T2) | (state_reg == S_T3);
   wire logic style = sys_ctrl_reg[`STYLE_BIT];
   // Byte writes copy the byte to both lanes; the unused one is don't-care.
   wire logic [15:0] wlane = byte_acc ? {2{wdata_reg[7:0]}} :
                             half_reg ? wdata_reg[31:16] :
                             wdata_reg[15:0];

   assign strobes.address_latch_strobe = in_t1;
   assign strobes.data_strobe_n = ~(active & ~style);
   // Direction drops back to read at cycle end, so it may show high
   // just before the hold acknowledge falls.
   assign strobes.rw = ~(active & write_reg);
   assign strobes.low_byte_enable_n = ~(active & ~style & lo_lane);
   assign strobes.high_byte_enable_n = ~(active & hi_lane);
   assign strobes.read_strobe_n = ~(active & style & ~write_reg);
   assign strobes.write_low_strobe_n = ~(active & style & write_reg &
                                         lo_lane);
   assign strobes.write_high_strobe_n = ~(active & style & write_reg &
                                          hi_lane);
   assign ad_out = in_t1 ? eff_addr[15:0] : wlane;
   assign ad_oe = in_t1 | (active & write_reg) & ~hold_active;
   assign addr_hi = eff_addr[23:16];
   assign strobe_oe = ~hold_active;
   assign hold_ack_n = ~(hold_pins_en & hold_active);

   a_hold_floats_bus: assert property (@(posedge pclk) disable iff (!presetn)
      !hold_ack_n |-> !ad_oe && !strobe_oe)
      else $error("Bus driven while hold acknowledged.");

   a_hold_pins_off: assert property (@(posedge pclk) disable iff (!presetn)
      !hold_pins_en && in_idle |=> !hold_active)
      else $error("Hold acknowledged with hold pins disabled.");

   a_no_hold_rmw: assert property (@(posedge pclk) disable iff (!presetn)
      in_idle && rmw_lock_reg |=> state_reg != S_HOLD)
      else $error("Hold granted inside read-modify-write.");

   a_stop_no_hold: assert property (@(posedge pclk) disable iff (!presetn)
      in_idle && pwr_stop_idle |=> state_reg != S_HOLD)
      else $error("Hold entered in stop or idle mode.");

   a_hold_ack_fast: assert property (@(posedge pclk) disable iff (!presetn)
      in_idle && hold_req && !rmw_lock_reg && !pwr_stop_idle
      |=> !hold_ack_n)
      else $error("Hold not acknowledged after free request.");

   a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
      hold_active && !hold_req |=> in_idle ##0 hold_ack_n)
      else $error("Hold not released after request removed.");

   a_idle_after_t3: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == S_T3 && idle_en |=> state_reg == S_TI)
      else $error("Idle state missing after third bus state.");

   a_rom_no_idle: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == S_T3 && cur_blk == `BLK_ROM |=> state_reg != S_TI)
      else $error("Idle state inserted for block 0.");

   a_word_back: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == S_T3 && more |=> state_reg inside {S_T1, S_TI}
      ##[0:1] state_reg == S_T1)
      else $error("Word halves not back to back.");

   a_periph_nop: assert property (@(posedge pclk) disable iff (!presetn)
      br_nop || seq_nop |=> rd_data[15:0] == `NOP_CODE && in_idle
      && (br_done || seq_done))
      else $error("Peripheral fetch did not return no-op.");

   a_op_first: assert property (@(posedge pclk) disable iff (!presetn)
      pick_ok && op_req.valid |-> op_accept && !br_accept && !seq_accept)
      else $error("Operand access lost arbitration.");

   a_word_align: assert property (@(posedge pclk) disable iff (!presetn)
      in_t1 && size_reg == SZ_WORD |-> addr_reg[1:0] == 2'b00)
      else $error("Misaligned word access on the bus.");
endmodule

/* tb_ext_bus_hold_idle_ctrl.sv */
`include "ehic_regs.svh"
module tb_ext_bus_hold_idle_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import ehic_pkg::*;
   localparam logic [31:0] A_IDLE = `IDLE_CTRL_IDX << 2;
   localparam logic [31:0] A_MODE = `MEM_MODE_IDX << 2;
   localparam logic [31:0] A_SYS = `SYS_CTRL_IDX << 2;
   logic pclk;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_data;
   logic pready, pslverr, op_accept, op_done, br_accept, br_done;
   logic seq_accept, seq_done, hold_ack_n, ad_oe, strobe_oe;
   ehic_op_req_t op_req = '0;
   ehic_fetch_req_t br_req = '0;
   ehic_fetch_req_t seq_req = '0;
   logic pwr_stop_idle = 1'b0;
   logic hold_request_n = 1'b1;
   logic [15:0] ad_in, ad_out;
   logic [7:0] addr_hi;
   ehic_strobes_t strobes;
   logic ack_low = 1'b0;
   int error_cnt = 0;
   int samples_checked = 0;

   ehic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_req(op_req),
      .op_accept(op_accept), .op_done(op_done), .br_req(br_req),
      .br_accept(br_accept), .br_done(br_done), .seq_req(seq_req),
      .seq_accept(seq_accept), .seq_done(seq_done), .rd_data(rd_data),
      .pwr_stop_idle(pwr_stop_idle), .hold_request_n(hold_request_n),
      .hold_ack_n(hold_ack_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .addr_hi(addr_hi), .strobes(strobes), .strobe_oe(strobe_oe));
   ehic_mem_model u_mem (.pclk(pclk), .ad_out(ad_out), .ad_oe(ad_oe),
      .addr_hi(addr_hi), .strobes(strobes), .strobe_oe(strobe_oe),
      .ad_in(ad_in));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   function automatic logic [15:0] exp_half(input logic [23:0] a);
      return a[15:0] ^ {a[23:16], a[23:16]};
   endfunction
   function automatic logic exp_idle(input logic [15:0] bcc,
                                     input logic [3:0] blk);
      return (blk == `BLK_ROM || blk == `BLK_INT) ? 1'b0 : bcc[{blk[3:1], 1'b1}];
   endfunction
   function automatic logic sig(input int w);
      case (w)
         0: return op_accept;
         1: return op_done;
         2: return br_done;
         3: return seq_done;
         4: return hold_ack_n;
         default: return pready;
      endcase
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wait_on(input int w, input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (hold_ack_n === 1'b0) ack_low = 1'b1;
      end while (sig(w) !== lvl && n < 40);
      if (n >= 40) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_on(5, 1'b1, n);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic op_run(input ehic_op_req_t a, input ehic_op_req_t b,
                         input logic hmid, output int gap);
      int n;
      op_req <= a;
      wait_on(0, 1'b1, n);
      ack_low = 1'b0;
      if (hmid) hold_request_n <= 1'b0;
      op_req <= b;
      gap = 0;
      if (b.valid) begin
         wait_on(0, 1'b1, gap);
         op_req <= '0;
      end
      wait_on(1, 1'b1, n);
   endtask
   task automatic hold_check();
      int n;
      wait_on(4, 1'b0, n);
      repeat (3) @(posedge pclk);
      chk(hold_ack_n, 1'b0);
      chk({ad_oe, strobe_oe}, 2'h0);
      hold_request_n <= 1'b1;
      wait_on(4, 1'b1, n);
      chk(strobe_oe, 1'b1);
   endtask
   task automatic no_hold();
      hold_request_n <= 1'b0;
      ack_low = 1'b0;
      repeat (10) @(posedge pclk);
      hold_request_n <= 1'b1;
      @(posedge pclk);
      chk(ack_low | (hold_ack_n !== 1'b1), 1'b0);
   endtask

   initial begin
      logic [31:0] rd;
      logic err;
      logic [15:0] bcc;
      logic [3:0] blk;
      logic [23:0] ad;
      logic [7:0] bt;
      int gap;
      int n;
      int ord;
      ehic_op_req_t a;
      ehic_op_req_t b;
      void'($urandom(32'h2259));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_IDLE, 32'h0, rd, err);
      chk(rd, `IDLE_CTRL_RST);
      apb(1'b0, A_MODE, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, A_SYS, 32'h0, rd, err);
      chk(rd, 32'h0);
      apb(1'b0, 32'h00000100, 32'h0, rd, err);
      chk(rd, 32'h0);
      chk(err, 1'b1);
      $display("register test done");
      for (int i = 0; i < 10; i++) begin
         // Even bits stay clear, as software must keep them.
         bcc = (i < 2) ? 16'hAAAA : 16'($urandom) & 16'hAAAA;
         apb(1'b1, A_IDLE, {16'h0, bcc}, rd, err);
         apb(1'b0, A_IDLE, 32'h0, rd, err);
         chk(rd, {16'h0, bcc});
         blk = (i == 0) ? `BLK_ROM : (i == 1) ? `BLK_INT : 4'($urandom);
         ad = {blk, 4'h0, 15'($urandom), 1'b0};
         a = '{1'b1, 1'b0, 1'b0, SZ_HALF, ad, 32'h0};
         b = a;
         b.addr = ad + 24'h2;
         op_run(a, b, 1'b0, gap);
         chk(gap, 4 + exp_idle(bcc, blk));
         chk(rd_data[15:0], exp_half(b.addr));
      end
      $display("idle state test done");
      apb(1'b1, A_MODE, 32'h8, rd, err);
      ad = {8'h50, 14'($urandom), 2'h0};
      a = '{1'b1, 1'b0, 1'b0, SZ_WORD, ad, 32'h0};
      op_run(a, '0, 1'b1, gap);
      chk(ack_low, 1'b0);
      chk(rd_data, {exp_half(ad + 24'h2), exp_half(ad)});
      hold_check();
      a = '{1'b1, 1'b0, 1'b1, SZ_HALF, ad, 32'h0};
      b = '{1'b1, 1'b1, 1'b0, SZ_HALF, ad, 32'($urandom)};
      op_run(a, b, 1'b1, gap);
      chk(ack_low, 1'b0);
      hold_check();
      pwr_stop_idle <= 1'b1;
      no_hold();
      pwr_stop_idle <= 1'b0;
      apb(1'b1, A_MODE, 32'h0, rd, err);
      no_hold();
      $display("hold test done");
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, A_SYS, 32'(s >> 1), rd, err);
         bt = 8'($urandom);
         ad = {8'h30, 15'($urandom), s[0]};
         a = '{1'b1, 1'b1, 1'b0, SZ_BYTE, ad, {4{bt}}};
         b = '{1'b1, 1'b0, 1'b0, SZ_HALF, {ad[23:1], 1'b0}, 32'h0};
         op_run(a, b, 1'b0, gap);
         chk(u_mem.wr_lanes, s[0] ? 2'h2 : 2'h1);
         chk(s[0] ? u_mem.wr_data[15:8] : u_mem.wr_data[7:0], bt);
         chk(rd_data[15:0], exp_half(b.addr));
      end
      $display("strobe style test done");
      op_req <= '{1'b1, 1'b0, 1'b0, SZ_HALF, 24'h200000, 32'h0};
      br_req <= '{1'b1, 24'h300000};
      seq_req <= '{1'b1, 24'h300100};
      ord = 0;
      repeat (60) begin
         @(posedge pclk);
         if (op_accept === 1'b1) op_req <= '0;
         if (br_accept === 1'b1) br_req <= '0;
         if (seq_accept === 1'b1) seq_req <= '0;
         n = {op_accept, br_accept, seq_accept};
         if (n != 0) ord = ord * 8 + n;
      end
      chk(ord, 32'h111);
      for (int k = 0; k < 2; k++) begin
         n = u_mem.address_latch_strobe_cnt;
         if (k == 0) br_req <= '{1'b1, 24'hFFF010};
         else seq_req <= '{1'b1, 24'hFFF000};
         wait_on(2 + k, 1'b1, gap);
         br_req <= '0;
         seq_req <= '0;
         repeat (3) @(posedge pclk);
         chk(rd_data[15:0], `NOP_CODE);
         chk(u_mem.address_latch_strobe_cnt, n);
      end
      $display("priority and fetch test done");
      stop_test();
   end
endmodule
